// file: pkg/synth_port_pkg.sv
// constants shared by the serial programming port, its assertion checker and its testbench
package synth_port_pkg;

   // transfer lengths that select a register, plus the cascade limit and the bit count top
   localparam logic [5:0] CFG_LEN = 6'h08;
   localparam logic [5:0] REF_LEN = 6'h10;
   localparam logic [5:0] LOOP_LEN = 6'h18;
   localparam logic [5:0] CASCADE_LIMIT = 6'h20;
   localparam logic [5:0] BIT_CNT_MAX = 6'h3F;

   // register widths
   localparam int CFG_W = 8;
   localparam int REF_W = 16;
   localparam int LOOP_W = 24;
   localparam int REF_DIV_W = 13;
   localparam int REF_MODE_W = 3;
   localparam int N_W = 12;
   localparam int A_W = 6;
   localparam int VCO_W = 18;

   // field positions
   localparam int OUTSEL_HI = 23;
   localparam int OUTSEL_LO = 22;
   localparam int N_LSB = 6;
   localparam int PORT_LEVEL_POS = 1;
   localparam int DRAIN_RELEASE_POS = 0;

   // output A source selections
   localparam logic [1:0] OUTSEL_REF = 2'h3;
   localparam logic [1:0] OUTSEL_VCO = 2'h2;
   localparam logic [1:0] OUTSEL_CASCADE = 2'h1;
   localparam logic [1:0] OUTSEL_PORT = 2'h0;

   // reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [12:0] REF_DIV_RST = 13'h0000;
   localparam logic [2:0] REF_MODE_RST = 3'h0;
   localparam logic [23:0] LOOP_RST = 24'h400000;

   // divide value that passes the reference straight through
   localparam logic [12:0] REF_PASS = 13'h0001;

endpackage : synth_port_pkg

// file: verilog/pin_sync.sv
// two-flop synchroniser for pins arriving from outside ref_clk
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk, // sampling clock
   input wire logic rst_n, // async reset, active low
   input wire logic ce, // clock enable, freezes state when low
   input wire logic [W-1:0] pin_in, // raw pins
   output logic [W-1:0] pin_out // synchronised pins
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t state_q;
   sync_state_t state_d;

   // first stage feeds only the second stage
   always_comb
   begin
      state_d = state_q;
      if (ce)
      begin
         state_d.meta = pin_in;
         state_d.stable = state_q.meta;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign pin_out = state_q.stable;

endmodule : pin_sync

`default_nettype wire

// file: verilog/synth_serial_program_port.sv
// serial programming port, dividers and output A/B of the synthesizer
`timescale 1ns/1ps
`default_nettype none

module synth_serial_program_port
   import synth_port_pkg::*;
(
   input wire logic ref_clk, // 10 MHz system clock
   input wire logic rst_n, // async power-on reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   input wire logic serial_clk, // serial clock pin from host
   input wire logic serial_data, // serial data pin from host
   input wire logic port_select_n, // enable pin, active low
   input wire logic ref_in, // reference input pin
   input wire logic rf_in, // prescaled vco input pin
   output logic out_a, // configurable output A
   output logic out_b_o, // output B drive level, always low
   output logic out_b_oe, // output B enable, high while pulling low
   output logic ref_divided_pulse, // reference divider pulse
   output logic vco_divided_pulse, // vco divider pulse
   output logic [2:0] ref_osc_mode, // reference top bits, unbuffered
   output logic [7:0] cfg_value // configuration register contents
);

   typedef struct packed {
      // edge history of the synchronised pins
      logic sclk_prev;
      logic sel_prev;
      logic ref_prev;
      logic rf_prev;
      // link synchronisation and the shift path
      logic in_sync;
      logic [5:0] bit_cnt;
      logic [LOOP_W-1:0] shift;
      logic half_stage;
      // registers written by the host
      logic [CFG_W-1:0] cfg;
      logic [REF_DIV_W-1:0] ref_buf1;
      logic [REF_DIV_W-1:0] ref_buf2;
      logic [REF_MODE_W-1:0] ref_mode;
      logic [LOOP_W-1:0] loop;
      // divider counters
      logic [REF_DIV_W-1:0] ref_cnt;
      logic [VCO_W-1:0] vco_cnt;
      logic ref_pulse;
      logic vco_pulse;
      // registered pin outputs
      logic out_a;
      logic out_b_oe;
   } port_state_t;

   localparam port_state_t STATE_RST = '{
      sclk_prev: 1'b0,
      sel_prev: 1'b1,
      ref_prev: 1'b0,
      rf_prev: 1'b0,
      in_sync: 1'b1,
      bit_cnt: 6'h00,
      shift: 24'h000000,
      half_stage: 1'b0,
      cfg: CFG_RST,
      ref_buf1: REF_DIV_RST,
      ref_buf2: REF_DIV_RST,
      ref_mode: REF_MODE_RST,
      loop: LOOP_RST,
      ref_cnt: 13'h0000,
      vco_cnt: 18'h00000,
      ref_pulse: 1'b0,
      vco_pulse: 1'b0,
      out_a: 1'b0,
      out_b_oe: 1'b1
   };

   port_state_t state_q;
   port_state_t state_d;

   logic [4:0] pins_sync;
   logic sclk_s;
   logic sdata_s;
   logic sel_s;
   logic ref_s;
   logic rf_s;

   // every pin crosses two flops before any logic reads it; a pin level
   // shorter than one ref_clk period can slip through unseen, so each
   // serial clock half period must span several ref_clk periods
   // the enable travels inverted so that the synchroniser's reset level
   // of zero equals its idle level; otherwise a false enable edge
   // would follow every reset
   pin_sync #(
      .W(5)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ce(ce),
      .pin_in({serial_clk, serial_data, ~port_select_n, ref_in, rf_in}),
      .pin_out(pins_sync)
   );

   assign sclk_s = pins_sync[4];
   assign sdata_s = pins_sync[3];
   assign sel_s = ~pins_sync[2]; // back to active low
   assign ref_s = pins_sync[1];
   assign rf_s = pins_sync[0];

   // edge events seen on the synchronised pins; each compares the
   // second flop with a copy one cycle older, so an event lasts one
   // ref_clk cycle and appears two edges after the pin moved
   // the history flops reset to the idle pin levels, so no false edge
   // is seen when reset is released
   logic sclk_rise;
   logic sclk_fall;
   logic sel_rise;
   logic sel_fall;
   logic sel_moved;
   logic ref_rise;
   logic rf_rise;

   assign sclk_rise = sclk_s & ~state_q.sclk_prev;
   assign sclk_fall = ~sclk_s & state_q.sclk_prev;
   assign sel_rise = sel_s & ~state_q.sel_prev;
   assign sel_fall = ~sel_s & state_q.sel_prev;
   assign sel_moved = sel_s ^ state_q.sel_prev;
   assign ref_rise = ref_s & ~state_q.ref_prev;
   assign rf_rise = rf_s & ~state_q.rf_prev;

   // loop register layout: a in bits 5:0, n in bits 17:6, bits 21:18
   // unused, bits 23:22 pick the source for output A
   // vco total is n*64+a; a is exactly six bits so the fields abut
   logic [N_W-1:0] n_val;
   logic [A_W-1:0] a_val;
   logic [VCO_W-1:0] vco_total;
   logic [VCO_W-1:0] vco_last;
   logic [1:0] outsel;

   assign n_val = state_q.loop[N_LSB +: N_W];
   assign a_val = state_q.loop[A_W-1:0];
   assign vco_total = {n_val, a_val};
   // terminal count; the counter restarts at zero on the edge after it
   assign vco_last = vco_total - 18'h00001;
   assign outsel = state_q.loop[OUTSEL_HI:OUTSEL_LO];

   // reference terminal count comes from the second buffer only,
   // so a 16-bit write alone never disturbs a running division
   logic [REF_DIV_W-1:0] ref_last;
   logic ref_bypass;

   assign ref_last = state_q.ref_buf2 - REF_PASS;
   assign ref_bypass = (state_q.ref_buf2 == REF_PASS);

   // fields of the word held in the shift register at frame close;
   // the newest bits sit at the bottom, so every register takes the
   // low end whatever came before it in the stream, which is what
   // lets a longer cascade stream pass through without steering bits
   logic [CFG_W-1:0] cfg_field;
   logic [REF_DIV_W-1:0] ref_div_field;
   logic [REF_MODE_W-1:0] ref_mode_field;

   assign cfg_field = state_q.shift[CFG_W-1:0];
   assign ref_div_field = state_q.shift[REF_DIV_W-1:0];
   assign ref_mode_field = state_q.shift[REF_W-1:REF_DIV_W];

   // transfer decode, used when the enable returns high
   logic load_cfg;
   logic load_ref;
   logic load_loop;
   logic load_empty;
   logic frame_ok;

   // the frame closes on the enable's rising edge with the clock low;
   // a frame whose enable moved with the clock high is dropped, and a
   // close with no clocks at all is the empty pulse that only moves
   // the first reference buffer into the second
   // counts of 8, 16 and 24 pick the register; any other count, the
   // cascade lengths above 32 included, stores nothing, so a stray
   // or cut frame cannot corrupt a register
   assign frame_ok = sel_rise & state_q.in_sync & ~sclk_s;
   assign load_cfg = frame_ok && (state_q.bit_cnt == CFG_LEN);
   assign load_ref = frame_ok && (state_q.bit_cnt == REF_LEN);
   assign load_loop = frame_ok && (state_q.bit_cnt == LOOP_LEN);
   assign load_empty = frame_ok && (state_q.bit_cnt == 6'h00);

   // one pass per ref_clk: edge history, link synchronisation, shifting,
   // frame close, the two dividers and the output registers; every
   // update is gated by ce so a low enable freezes the whole port
   always_comb
   begin
      state_d = state_q;
      if (ce)
      begin
         state_d.sclk_prev = sclk_s;
         state_d.sel_prev = sel_s;
         state_d.ref_prev = ref_s;
         state_d.rf_prev = rf_s;

         // synchronisation: lost on enable motion with clock high,
         // regained only once enable is high and clock is low
         if (sel_moved && sclk_s)
            state_d.in_sync = 1'b0;
         else if (sel_s && !sclk_s)
            state_d.in_sync = 1'b1;

         // port idles while the enable is high
         if (sel_s || sel_fall)
            state_d.bit_cnt = 6'h00;
         else if (sclk_rise && state_q.in_sync)
         begin
            // msb arrives first, so data walks up toward bit 23
            state_d.shift = {state_q.shift[LOOP_W-2:0], sdata_s};
            // count saturates so long cascade frames never alias
            if (state_q.bit_cnt != BIT_CNT_MAX)
               state_d.bit_cnt = state_q.bit_cnt + 6'h01;
         end

         // half stage updates only on the falling clock edge
         if (!sel_s && sclk_fall && state_q.in_sync)
            state_d.half_stage = state_q.shift[LOOP_W-1];

         // no steering bits: the length alone names the target
         if (load_cfg)
            state_d.cfg = cfg_field;
         // top three reference bits act at once; the low bits wait in
         // the first buffer for a 24-bit load or an empty pulse
         if (load_ref)
         begin
            state_d.ref_buf1 = ref_div_field;
            state_d.ref_mode = ref_mode_field;
         end
         if (load_loop)
         begin
            state_d.loop = state_q.shift;
            state_d.ref_buf2 = state_q.ref_buf1;
         end
         if (load_empty)
            state_d.ref_buf2 = state_q.ref_buf1;
         // every other count falls through with nothing stored

         // reference counter, pulse high for one cycle; with a divide
         // of one every input edge passes straight through, otherwise
         // the count wraps at the terminal value from the second buffer
         state_d.ref_pulse = 1'b0;
         if (ref_rise)
         begin
            if (ref_bypass)
               state_d.ref_pulse = 1'b1;
            else if (state_q.ref_cnt >= ref_last)
            begin
               state_d.ref_cnt = '0;
               state_d.ref_pulse = 1'b1;
            end
            else
               state_d.ref_cnt = state_q.ref_cnt + REF_PASS;
         end

         // vco counter; compares against the live total so a new
         // value takes effect at the next terminal count
         state_d.vco_pulse = 1'b0;
         if (rf_rise)
         begin
            if (state_q.vco_cnt >= vco_last)
            begin
               state_d.vco_cnt = '0;
               state_d.vco_pulse = 1'b1;
            end
            else
               state_d.vco_cnt = state_q.vco_cnt + 18'h00001;
         end

         // output A source select
         case (outsel)
            OUTSEL_REF: state_d.out_a = state_q.ref_pulse;
            OUTSEL_VCO: state_d.out_a = state_q.vco_pulse;
            OUTSEL_CASCADE: state_d.out_a = state_q.half_stage;
            OUTSEL_PORT:
               state_d.out_a = state_q.cfg[PORT_LEVEL_POS];
            default: state_d.out_a = 1'b0;
         endcase

         // open drain: pull low while the release bit is clear
         state_d.out_b_oe = ~state_q.cfg[DRAIN_RELEASE_POS];
      end
   end

   // limitations worth knowing: divide values 0 and 2 to 4 are not
   // blocked and give no useful pulse train; the shift register keeps
   // its contents across frames, only the bit count restarts; counts
   // of 63 and more saturate at the counter's top and store nothing, which
   // leaves a long cascade stream to the devices further down; ce low
   // freezes the synchroniser as well, so pin edges that come and go
   // while it is low are never seen; the dividers compare against the
   // live registers, so a new value takes effect at the next wrap
   // rather than restarting the count

   // reset puts A in cascade mode and B pulled low
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= STATE_RST;
      else
         state_q <= state_d;
   end

   // outputs straight from flops; out_b_o is tied low because B is an
   // open-drain pin and only its enable carries the configured level
   // the divider pulses are also brought out so a phase detector
   // outside this block can use them whatever A is showing
   assign out_a = state_q.out_a;
   assign out_b_o = 1'b0;
   assign out_b_oe = state_q.out_b_oe;
   assign ref_divided_pulse = state_q.ref_pulse;
   assign vco_divided_pulse = state_q.vco_pulse;
   assign ref_osc_mode = state_q.ref_mode;
   assign cfg_value = state_q.cfg;

endmodule : synth_serial_program_port

`default_nettype wire

// file: verification/synth_port_asserts.sv
// timing checks on the serial programming port outputs
`timescale 1ns/1ps
`default_nettype none

module synth_port_asserts
   import synth_port_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic ref_in, // reference pin
   input wire logic rf_in, // vco-side pin
   input wire logic port_select_n, // enable pin, active low
   input wire logic out_b_o, // B drive level
   input wire logic out_b_oe, // B enable
   input wire logic ref_divided_pulse, // ref pulse
   input wire logic vco_divided_pulse, // vco pulse
   input wire logic [2:0] ref_osc_mode, // ref top bits
   input wire logic [7:0] cfg_value // config contents
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // open drain: never drives high
   a_b_pulls_low: assert property (out_b_o == 1'b0)
      else $error("output B drive level high");
   a_b_follows_cfg: assert property (out_b_oe == !$past(cfg_value[0]))
      else $error("output B enable not from config bit 0");
   a_reset_values: assert property ($rose(rst_n) |->
      out_b_oe && cfg_value == CFG_RST && ref_osc_mode == REF_MODE_RST)
      else $error("bad values out of reset");
   // loads only after the enable has been high a while
   a_cfg_on_close: assert property ($changed(cfg_value) |->
      $past(port_select_n, 2) && $past(port_select_n, 3))
      else $error("config changed while shifting");
   a_mode_on_close: assert property ($changed(ref_osc_mode) |->
      $past(port_select_n, 2) && $past(port_select_n, 3))
      else $error("ref top bits changed while shifting");
   a_ref_one_cycle: assert property (ref_divided_pulse |=>
      !ref_divided_pulse)
      else $error("ref pulse longer than one cycle");
   a_vco_one_cycle: assert property (vco_divided_pulse |=>
      !vco_divided_pulse)
      else $error("vco pulse longer than one cycle");
   // a pulse needs a recent rising edge at its input
   a_ref_from_edge: assert property (ref_divided_pulse |->
      $past(ref_in, 3) && !$past(ref_in, 6))
      else $error("ref pulse without input edge");
   a_vco_from_edge: assert property (vco_divided_pulse |->
      $past(rf_in, 3) && !$past(rf_in, 6))
      else $error("vco pulse without input edge");
endmodule : synth_port_asserts

bind synth_serial_program_port synth_port_asserts u_chk (.ref_clk, .rst_n,
   .ref_in, .rf_in, .port_select_n, .out_b_o, .out_b_oe, .ref_divided_pulse,
   .vco_divided_pulse, .ref_osc_mode, .cfg_value);
`default_nettype wire

// file: verification/host_model.sv
// host that frames transfers on the serial programming port
`timescale 1ns/1ps
`default_nettype none

module host_model (
   input wire logic ref_clk, // timing reference
   output logic serial_clk, // serial clock
   output logic serial_data, // serial data
   output logic port_select_n // enable, active low
);
   // clock low and enable high at power up
   initial
   begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      port_select_n = 1'b1;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : hold

   // 800 ns serial clock; len 0 gives an empty enable pulse
   task automatic send(input int len, input logic [47:0] val);
      int i;
      serial_clk = 1'b1; // stray edge while idle
      hold(4);
      serial_clk = 1'b0;
      hold(4);
      port_select_n = 1'b0; // clock low here
      for (i = len - 1; i >= 0; i--)
      begin
         serial_data = val[i]; // msb first
         hold(4);
         serial_clk = 1'b1;
         hold(4);
         serial_clk = 1'b0;
      end
      hold(4);
      port_select_n = 1'b1;
      serial_data = ~serial_data; // stale data is not kept
      hold(8);
   endtask : send
endmodule : host_model
`default_nettype wire

// file: verification/tb_synth_serial_program_port.sv
// self-checking bench for the serial programming port
`timescale 1ns/1ps
`default_nettype none

module tb_synth_serial_program_port;
   import synth_port_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ref_in = 1'b0;
   logic rf_in = 1'b0;
   logic sclk, sdat, sel_n, out_a, b_o, b_oe, rp, vp;
   logic [2:0] mode;
   logic [7:0] cfg;
   int err_count = 0;
   int checks_done = 0;
   int nr, nv, na;

   always #50 ref_clk = ~ref_clk;

   host_model u_host (.ref_clk, .serial_clk(sclk), .serial_data(sdat),
      .port_select_n(sel_n));
   synth_serial_program_port u_dut (.ref_clk, .rst_n, .ce(1'b1),
      .serial_clk(sclk), .serial_data(sdat), .port_select_n(sel_n),
      .ref_in, .rf_in, .out_a, .out_b_o(b_o), .out_b_oe(b_oe),
      .ref_divided_pulse(rp), .vco_divided_pulse(vp),
      .ref_osc_mode(mode), .cfg_value(cfg));

   // pulse counters for the dividers and output A
   always @(posedge ref_clk)
   begin
      if (rp === 1'b1) nr++;
      if (vp === 1'b1) nv++;
      if (out_a === 1'b1) na++;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   // n rising edges, 400 ns half period, pulses under 2 MHz
   task automatic toggle(input bit vco, input int n);
      nr = 0;
      nv = 0;
      na = 0;
      repeat (2 * n)
      begin
         repeat (4) @(posedge ref_clk);
         #1;
         if (vco) rf_in = ~rf_in;
         else ref_in = ~ref_in;
      end
      repeat (12) @(posedge ref_clk);
      #1;
   endtask : toggle

   initial
   begin
      repeat (16) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      check(cfg, CFG_RST);
      check(8'({out_a, b_o, b_oe}), 8'h01);
      u_host.send(8, 8'h03);
      check(cfg, 8'h03);
      check(8'(b_oe), 8'h00);
      // port mode, n 2 not below a 2
      u_host.send(24, 24'h000082);
      check(8'(out_a), 8'h01);
      u_host.send(8, 8'h00);
      check(8'({out_a, b_oe}), 8'h01);
      // cascade-length frame, open to the host, must store nothing
      u_host.send(40, 40'hFFFFFFFFFF);
      check(cfg, 8'h00);
      // divide 5 reaches the counter by an empty pulse
      u_host.send(16, 16'hA005);
      check(8'(mode), 8'h05);
      u_host.send(0, 0);
      toggle(1'b0, 20);
      check(8'(nr), 8'h04);
      // divide 1 waits in the first buffer
      u_host.send(16, 16'hA001);
      toggle(1'b0, 10);
      check(8'(nr), 8'h02);
      u_host.send(24, 24'hC00082);
      toggle(1'b0, 7);
      check(8'(nr), 8'h07);
      check(8'(na), 8'h07);
      // vco ratio 2 * 64 + 2
      toggle(1'b1, 260);
      check(8'(nv), 8'h02);
      u_host.send(24, 24'h800082);
      toggle(1'b1, 130);
      check(8'(nv), 8'h01);
      check(8'(na), 8'h01);
      // cascade out shows the bit shifted in 23 clocks earlier
      u_host.send(24, 24'h400082);
      check(8'(out_a), 8'h00);
      u_host.send(16, 16'hA005);
      check(8'(out_a), 8'h01);
      results();
   end

   // whole run is near 530 us
   initial
   begin
      #2000000;
      err_count++;
      results();
   end
endmodule : tb_synth_serial_program_port
`default_nettype wire
